/* File: hdl/pfc_defines.vh */
/*
  Offsets, field positions, reset values and encodings for the dual-slope
  PWM timer. Assumes a 32-bit APB register bus, one aligned word per register.
*/
`ifndef PFC_DEFINES_VH
`define PFC_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PFC_ADDR_W        8
`define PFC_OFS_CTRL      8'h00
`define PFC_OFS_CMP_A     8'h04
`define PFC_OFS_CMP_B     8'h08
`define PFC_OFS_CMP_C     8'h0C
`define PFC_OFS_CAPT      8'h10
`define PFC_OFS_COUNT     8'h14
`define PFC_OFS_FLAGS     8'h18
`define PFC_OFS_PORT      8'h1C

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define PFC_CTRL_MODE_LSB 0
`define PFC_CTRL_ACTA_LSB 4
`define PFC_CTRL_ACTB_LSB 6
`define PFC_CTRL_ACTC_LSB 8
`define PFC_CTRL_CSEL_LSB 10
`define PFC_CTRL_DIR_LSB  13
`define PFC_CTRL_W        16
`define PFC_CTRL_RESET    16'h0000

// ----------------------------------------------------------------
// flag register bits
// ----------------------------------------------------------------
`define PFC_FLG_OVF       0
`define PFC_FLG_MATCH_LSB 1
`define PFC_FLG_CAPT      4
`define PFC_FLG_W         5

// ----------------------------------------------------------------
// encodings and values
// ----------------------------------------------------------------
`define PFC_MODE_TOP_CAPT 4'h8
`define PFC_MODE_TOP_CMPA 4'h9
`define PFC_MODE_TOGGLE_LO 4'h8
`define PFC_MODE_TOGGLE_HI 4'hB
`define PFC_ACT_OFF       2'h0
`define PFC_ACT_TOGGLE    2'h1
`define PFC_ACT_NONINV    2'h2
`define PFC_ACT_INV       2'h3
`define PFC_BOTTOM        16'h0000
`define PFC_CSEL_STOP     3'h0
`define PFC_CSEL_DIV1     3'h1
`define PFC_CSEL_DIV8     3'h2
`define PFC_CSEL_DIV64    3'h3
`define PFC_CSEL_DIV256   3'h4
`define PFC_CSEL_DIV1024  3'h5
`define PFC_NUM_CH        3

`endif

/* File: hdl/pfc_prescaler.v */
/*
  Prescaler for the PWM timer: a free-running divider that emits a
  one-cycle tick enable at clk_sys divided by 1, 8, 64, 256 or 1024.
  Assumes clk_sys is the only clock and rst_b is asynchronous, active low.
*/
`timescale 1ns/1ns
`include "pfc_defines.vh"

module pfc_prescaler (
  input  wire       clk_sys,
  input  wire       rst_b,
  input  wire [2:0] clk_sel,
  output wire       tick_en
);

  reg  [9:0] div_cnt_r;
  reg  [9:0] div_mask;
  reg        tick_on;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // free running so the tick phase does not depend on selector writes
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_r <= 10'h000;
    end else begin
      div_cnt_r <= div_cnt_r + 10'h001;
    end
  end

  always @* begin
    tick_on  = 1'b1;
    div_mask = 10'h000;
    case (clk_sel)
      `PFC_CSEL_DIV1:    div_mask = 10'h000;
      `PFC_CSEL_DIV8:    div_mask = 10'h007;
      `PFC_CSEL_DIV64:   div_mask = 10'h03F;
      `PFC_CSEL_DIV256:  div_mask = 10'h0FF;
      `PFC_CSEL_DIV1024: div_mask = 10'h3FF;
      default:           tick_on  = 1'b0;
    endcase
  end

  assign tick_en = tick_on & ((div_cnt_r & div_mask) == div_mask);

endmodule

/* File: hdl/pfc_pwm_timer.v */
/*
  Dual-slope, phase and frequency correct 16-bit PWM timer with three
  compare channels, an APB register slave and port-pin muxing.
  Assumes one clock clk_sys, asynchronous active-low rst_b, and an APB
  master on the same clock; pin enables are resolved outside.
*/
// Notes on behaviour
// - modes 8 and 9 select this PWM
// - count zero up to TOP, back down
// - non-inverting: clear rising match, set falling
// - selector two normal, three inverted PWM
// - TOP from capture (8) or compare A (9)
// - count holds TOP for one tick
// - match flag when count equals compare
// - overflow flag with buffer load at BOTTOM
// - TOP flag: channel A or capture flag
// - compare writes buffered, loaded at BOTTOM
// - compare above TOP never matches
// - pin driven only when direction bit set
// - compare BOTTOM low, compare TOP high
// - mode 9, selector one: A toggles
// - counter advances only on prescaler tick
// - period is two times prescale times TOP
// - selector one toggles only channel A
// - selector zero leaves normal port function
`timescale 1ns/1ns
`include "pfc_defines.vh"

module pfc_pwm_timer (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  output reg  [2:0]  pin_out,
  output reg  [2:0]  pin_oe
);

  // ----------------------------------------------------------------
  // state machine encoding: counting direction
  // ----------------------------------------------------------------
  localparam [1:0] ST_UP   = 2'b01;
  localparam [1:0] ST_DOWN = 2'b10;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg  [15:0] ctrl_r;
  reg  [15:0] cmp_buf_r [0:2];
  reg  [15:0] cmp_act_r [0:2];
  reg  [15:0] capture_value_r;
  reg  [15:0] count_value_r;
  reg  [1:0]  state_r;
  reg  [4:0]  flags_r;
  reg  [2:0]  port_data_r;
  reg  [2:0]  wave_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [3:0]  waveform_mode_sel;
  wire [2:0]  clk_sel;
  wire [2:0]  pin_direction_bit;
  wire        timer_tick_enable;
  wire        mode_run;
  wire        mode_toggle_ok;
  wire        step;
  wire [15:0] top_value;
  wire        setup_ph;
  wire        wr_acc;
  wire [7:0]  reg_ofs;
  wire        ofs_valid;

  reg  [15:0] count_nxt;
  reg  [1:0]  state_nxt;
  reg  [2:0]  match;
  reg  [2:0]  wave_nxt;
  reg  [4:0]  flags_set;
  reg  [4:0]  flags_nxt;
  reg         at_bottom;
  reg         at_top;
  reg         leave_down;
  integer     i;
  integer     j;

  assign waveform_mode_sel = ctrl_r[`PFC_CTRL_MODE_LSB +: 4];
  assign clk_sel           = ctrl_r[`PFC_CTRL_CSEL_LSB +: 3];
  assign pin_direction_bit = ctrl_r[`PFC_CTRL_DIR_LSB +: 3];

  // other counting modes are not built: the counter simply holds there
  assign mode_run = (waveform_mode_sel == `PFC_MODE_TOP_CAPT) ||
                    (waveform_mode_sel == `PFC_MODE_TOP_CMPA);

  assign mode_toggle_ok = (waveform_mode_sel >= `PFC_MODE_TOGGLE_LO) &&
                          (waveform_mode_sel <= `PFC_MODE_TOGGLE_HI);

  assign top_value = (waveform_mode_sel == `PFC_MODE_TOP_CMPA) ?
                     cmp_act_r[0] : capture_value_r;

  assign step = mode_run & timer_tick_enable;

  function [1:0] act_sel;
    input [15:0] ctrl;
    input [1:0]  ch;
    begin
      case (ch)
        2'd0:    act_sel = ctrl[`PFC_CTRL_ACTA_LSB +: 2];
        2'd1:    act_sel = ctrl[`PFC_CTRL_ACTB_LSB +: 2];
        default: act_sel = ctrl[`PFC_CTRL_ACTC_LSB +: 2];
      endcase
    end
  endfunction

  // channel connected to its pin for the current selector and mode
  function conn;
    input [1:0] act;
    input [1:0] ch;
    input       tog_ok;
    begin
      case (act)
        `PFC_ACT_OFF:    conn = 1'b0;
        `PFC_ACT_TOGGLE: conn = (ch == 2'd0) && tog_ok;
        default:         conn = 1'b1;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  pfc_prescaler u_presc (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clk_sel (clk_sel),
    .tick_en (timer_tick_enable)
  );

  // ----------------------------------------------------------------
  // counter and direction
  // ----------------------------------------------------------------
  // compare and flags look at the value the counter moves to, so that a
  // compare of BOTTOM or TOP falls on the turn and pins the output level
  always @* begin
    count_nxt = count_value_r;
    state_nxt = state_r;
    case (state_r)
      ST_UP: begin
        if (count_value_r >= top_value) begin
          count_nxt = count_value_r - 16'h0001;
          state_nxt = ST_DOWN;
        end else begin
          count_nxt = count_value_r + 16'h0001;
        end
      end
      ST_DOWN: begin
        if (count_value_r == `PFC_BOTTOM) begin
          count_nxt = count_value_r + 16'h0001;
          state_nxt = ST_UP;
        end else begin
          count_nxt = count_value_r - 16'h0001;
        end
      end
      default: begin
        count_nxt = `PFC_BOTTOM;
        state_nxt = ST_UP;
      end
    endcase
  end

  // turning points reached at this step; each slope spans TOP ticks
  always @* begin
    at_bottom = (state_r == ST_DOWN) && (count_nxt == `PFC_BOTTOM);
    at_top    = (state_r == ST_UP) && (count_nxt == top_value);
    // a turn counts as leaving in the new direction: TOP down, BOTTOM up
    leave_down = at_top | ((state_nxt == ST_DOWN) & ~at_bottom);
  end

  // ----------------------------------------------------------------
  // compare match and waveform
  // ----------------------------------------------------------------
  always @* begin
    wave_nxt = wave_r;
    for (i = 0; i < `PFC_NUM_CH; i = i + 1) begin
      // a compare above TOP is never reached by the counter
      match[i] = (count_nxt == cmp_act_r[i]) &&
                 (cmp_act_r[i] <= top_value);
      if (match[i]) begin
        case (act_sel(ctrl_r, i[1:0]))
          `PFC_ACT_TOGGLE: begin
            if (i == 0) begin
              wave_nxt[i] = ~wave_r[i];
            end
          end
          `PFC_ACT_NONINV: begin
            // leaving a match rising clears, falling sets
            wave_nxt[i] = leave_down;
          end
          `PFC_ACT_INV: begin
            wave_nxt[i] = ~leave_down;
          end
          default: begin
            wave_nxt[i] = wave_r[i];
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  always @* begin
    flags_set = 5'h00;
    if (step) begin
      flags_set[`PFC_FLG_OVF] = at_bottom;
      flags_set[`PFC_FLG_MATCH_LSB +: 3] = match;
      if (waveform_mode_sel == `PFC_MODE_TOP_CAPT) begin
        flags_set[`PFC_FLG_CAPT] = at_top;
      end else begin
        flags_set[`PFC_FLG_MATCH_LSB] = match[0] | at_top;
      end
    end
    flags_nxt = flags_r;
    if (wr_acc && reg_ofs == `PFC_OFS_FLAGS) begin
      flags_nxt = flags_r & ~pwdata[`PFC_FLG_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    flags_nxt = flags_nxt | flags_set;
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign reg_ofs   = paddr[`PFC_ADDR_W-1:0];
  assign setup_ph  = psel & ~penable;
  assign wr_acc    = psel & penable & pwrite & ofs_valid;
  assign ofs_valid = (paddr[31:`PFC_ADDR_W] == 24'h000000) &&
                     (reg_ofs[1:0] == 2'b00) && (reg_ofs <= `PFC_OFS_PORT);
  // zero wait state: read data is registered in the setup cycle
  assign pready    = 1'b1;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pslverr <= ~ofs_valid;
      prdata  <= 32'h00000000;
      if (!pwrite && ofs_valid) begin
        case (reg_ofs)
          `PFC_OFS_CTRL:  prdata <= {16'h0000, ctrl_r};
          `PFC_OFS_CMP_A: prdata <= {16'h0000, cmp_buf_r[0]};
          `PFC_OFS_CMP_B: prdata <= {16'h0000, cmp_buf_r[1]};
          `PFC_OFS_CMP_C: prdata <= {16'h0000, cmp_buf_r[2]};
          `PFC_OFS_CAPT:  prdata <= {16'h0000, capture_value_r};
          `PFC_OFS_COUNT: prdata <= {16'h0000, count_value_r};
          `PFC_OFS_FLAGS: prdata <= {27'h0000000, flags_r};
          `PFC_OFS_PORT:  prdata <= {29'h0000000, port_data_r};
          default:        prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // registers written by software
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r          <= `PFC_CTRL_RESET;
      capture_value_r <= 16'h0000;
      port_data_r     <= 3'h0;
      cmp_buf_r[0]    <= 16'h0000;
      cmp_buf_r[1]    <= 16'h0000;
      cmp_buf_r[2]    <= 16'h0000;
    end else if (wr_acc) begin
      case (reg_ofs)
        `PFC_OFS_CTRL:  ctrl_r          <= pwdata[15:0];
        `PFC_OFS_CMP_A: cmp_buf_r[0]    <= pwdata[15:0];
        `PFC_OFS_CMP_B: cmp_buf_r[1]    <= pwdata[15:0];
        `PFC_OFS_CMP_C: cmp_buf_r[2]    <= pwdata[15:0];
        `PFC_OFS_CAPT:  capture_value_r <= pwdata[15:0];
        `PFC_OFS_PORT:  port_data_r     <= pwdata[2:0];
        default:        port_data_r     <= port_data_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // timer state
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_value_r <= `PFC_BOTTOM;
      state_r       <= ST_UP;
      wave_r        <= 3'h0;
      flags_r       <= 5'h00;
      cmp_act_r[0]  <= 16'h0000;
      cmp_act_r[1]  <= 16'h0000;
      cmp_act_r[2]  <= 16'h0000;
    end else begin
      flags_r <= flags_nxt;
      // a software write to the count beats a tick in the same cycle
      if (wr_acc && reg_ofs == `PFC_OFS_COUNT) begin
        count_value_r <= pwdata[15:0];
      end else if (step) begin
        count_value_r <= count_nxt;
        state_r       <= state_nxt;
        wave_r        <= wave_nxt;
      end
      // loading only at BOTTOM keeps both slopes the same length
      if (step && at_bottom) begin
        cmp_act_r[0] <= cmp_buf_r[0];
        cmp_act_r[1] <= cmp_buf_r[1];
        cmp_act_r[2] <= cmp_buf_r[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= 3'h0;
      pin_oe  <= 3'h0;
    end else begin
      for (j = 0; j < `PFC_NUM_CH; j = j + 1) begin
        if (conn(act_sel(ctrl_r, j[1:0]), j[1:0], mode_toggle_ok)) begin
          pin_out[j] <= wave_r[j];
        end else begin
          pin_out[j] <= port_data_r[j];
        end
      end
      pin_oe <= pin_direction_bit;
    end
  end

endmodule

/* File: verification/pfc_monitor.sv */
/*
  Port-level checker for the dual-slope PWM timer: register bus replies,
  pin enables and the port-data fallback of disconnected channels.
  Assumes one clock clk_sys and asynchronous active-low rst_b.
*/
`timescale 1ns/1ns
`include "pfc_defines.vh"

module pfc_monitor (
  input wire        clk_sys,
  input wire        rst_b,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire [2:0]  pin_out,
  input wire [2:0]  pin_oe
);
  // ----------------------------------------------------------------
  // shadow registers
  // ----------------------------------------------------------------
  logic [15:0] ctrl_r;
  logic [2:0]  port_r;
  wire  [2:0]  off_m;
  logic        acc;
  logic        bad;
  logic        tog_md;
  assign acc = psel && penable;
  assign bad = (paddr[1:0] != 2'h0) || (paddr > {24'h0, `PFC_OFS_PORT});
  assign tog_md = ctrl_r[3:0] >= `PFC_MODE_TOGGLE_LO && ctrl_r[3:0] <= `PFC_MODE_TOGGLE_HI;
  // toggle action falls back to port data on B, C and outside modes 8..11
  assign off_m[0] = ctrl_r[5:4] == 2'h0 || (ctrl_r[5:4] == 2'h1 && !tog_md);
  assign off_m[1] = ctrl_r[7:6] < 2'h2;
  assign off_m[2] = ctrl_r[9:8] < 2'h2;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= 16'h0;
      port_r <= 3'h0;
    end else if (acc && pwrite) begin
      if (paddr == {24'h0, `PFC_OFS_CTRL}) ctrl_r <= pwdata[15:0];
      if (paddr == {24'h0, `PFC_OFS_PORT}) port_r <= pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ready_high_a: assert property (pready) else $error("pready low");
  oe_track_a: assert property ($stable(ctrl_r) |-> pin_oe == ctrl_r[15:13])
    else $error("pin enable differs from direction bits");
  err_flag_a: assert property (acc && bad |-> pslverr) else $error("no error on bad address");
  err_rdata_a: assert property (acc && bad && !pwrite |-> prdata == 32'h0)
    else $error("bad address read not zero");
  map_ok_a: assert property (acc && !bad |-> !pslverr) else $error("error on mapped address");
  upper_zero_a: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  ctrl_read_a: assert property (acc && !pwrite && paddr == 32'h0 |-> prdata[15:0] == ctrl_r)
    else $error("control readback wrong");
  port_mux_a: assert property ($stable(port_r) && $stable(off_m) |=>
    ((pin_out ^ $past(port_r)) & $past(off_m)) == 3'h0) else $error("port data not on pin");
  cover property (acc && pwrite && paddr == 32'h0);
  cover property (acc && bad);
  cover property ($rose(pin_out[1]));
endmodule

bind pfc_pwm_timer pfc_monitor u_mon (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .prdata, .pslverr, .pin_out, .pin_oe);

/* File: verification/pfc_load_model.sv */
/*
  Load on the three timer pins: resolves the pin level and counts high
  cycles and level changes per pin. Assumes the pins have no pull.
*/
`timescale 1ns/1ns

module pfc_load_model (
  input  wire              clk_sys,
  input  wire              clr,
  input  wire [2:0]        pin_out,
  input  wire [2:0]        pin_oe,
  output logic [2:0]       pin_lvl,
  output logic [2:0][15:0] hi_r,
  output logic [2:0][7:0]  tg_r
);
  logic [2:0] last_r = 3'h0;
  // undriven pin floats: show the inverse of last cycle's level, flipping every cycle
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ~last_r);
  always @(posedge clk_sys) begin
    last_r <= pin_lvl;
    for (int i = 0; i < 3; i++) begin
      hi_r[i] <= clr ? 16'h0 : hi_r[i] + pin_lvl[i];
      tg_r[i] <= clr ? 8'h0 : tg_r[i] + (pin_lvl[i] != last_r[i]);
    end
  end
endmodule

/* File: verification/dual_slope_pfc_pwm_timer_tb.sv */
/*
  Self-checking bench for the dual-slope PWM timer: register table rows,
  idle modes, PWM levels per prescale, toggle mode, flags and reset.
  Assumes the load model and the port checker bound to the design.
*/
`timescale 1ns/1ns
`include "pfc_defines.vh"

module dual_slope_pfc_pwm_timer_tb;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [15:0] e; logic x;} pfc_row_t;
  logic             clk_sys = 1'h0;
  logic             rst_b = 1'h0;
  logic             psel = 1'h0;
  logic             penable = 1'h0;
  logic             pwrite = 1'h0;
  logic [31:0]      paddr = 32'h0;
  logic [31:0]      pwdata = 32'h0;
  logic             clr = 1'h1;
  logic [31:0]      rd;
  logic             err;
  wire              pready;
  wire              pslverr;
  wire [31:0]       prdata;
  wire [2:0]        pin_out;
  wire [2:0]        pin_oe;
  wire [2:0]        pin_lvl;
  wire [2:0][15:0]  hi_r;
  wire [2:0][7:0]   tg_r;
  int               fails = 0;
  int               n_tests = 0;
  int               cyc = 0;
  pfc_row_t         rows[9];
  logic [3:0]       idl[3] = '{4'h0, 4'h7, 4'hA};
  logic [2:0]       csl[3] = '{3'h1, 3'h2, 3'h3};
  int               nv[3] = '{1, 8, 64};

  always #4 clk_sys = ~clk_sys;

  pfc_pwm_timer DUT (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .pin_out, .pin_oe);
  pfc_load_model u_load (.clk_sys, .clr, .pin_out, .pin_oe, .pin_lvl, .hi_r, .tg_r);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // stops the counter first so the new settings start from BOTTOM
  task automatic setup(input logic [15:0] c, ca, cb, cc, top);
    apb(1'h1, `PFC_OFS_CTRL, 32'hE000);
    apb(1'h1, `PFC_OFS_COUNT, 32'h0);
    apb(1'h1, `PFC_OFS_CAPT, {16'h0, top});
    apb(1'h1, `PFC_OFS_CMP_A, {16'h0, ca});
    apb(1'h1, `PFC_OFS_CMP_B, {16'h0, cb});
    apb(1'h1, `PFC_OFS_CMP_C, {16'h0, cc});
    apb(1'h1, `PFC_OFS_CTRL, {16'h0, c});
  endtask

  task automatic meas(input int settle, input int w);
    repeat (settle) @(posedge clk_sys);
    apb(1'h1, `PFC_OFS_FLAGS, 32'h1F);
    clr <= 1'h1;
    @(posedge clk_sys);
    clr <= 1'h0;
    repeat (w) @(posedge clk_sys);
    #1;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{'{8'h00, 32'hE000, 16'hE000, 1'h0}, '{8'h04, 32'hABCD0010, 16'h0010, 1'h0},
      '{8'h08, 32'h5, 16'h5, 1'h0}, '{8'h0C, 32'hFFFF, 16'hFFFF, 1'h0},
      '{8'h10, 32'h7, 16'h7, 1'h0}, '{8'h14, 32'h1234, 16'h1234, 1'h0},
      '{8'h1C, 32'h5, 16'h5, 1'h0}, '{8'h20, 32'h11, 16'h0, 1'h1},
      '{8'h02, 32'h11, 16'h0, 1'h1}};
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'h1;
    foreach (rows[i]) begin
      apb(1'h1, rows[i].a, rows[i].d);
      chk(err, rows[i].x);
      apb(1'h0, rows[i].a, 32'h0);
      chk(rd, {16'h0, rows[i].e});
      chk(err, rows[i].x);
    end
    chk(pin_oe, 32'h7);
    chk(pin_lvl, 32'h5);
    foreach (idl[i]) begin
      apb(1'h1, `PFC_OFS_COUNT, 32'h5);
      apb(1'h1, `PFC_OFS_CTRL, {16'h0, 12'hE40, idl[i]});
      repeat (20) @(posedge clk_sys);
      apb(1'h0, `PFC_OFS_COUNT, 32'h0);
      chk(rd, 32'h5);
    end
    // mode 8, TOP 10: A inverted at 0, B plain at 3, C plain at TOP
    foreach (csl[i]) begin
      setup({3'h7, csl[i], 10'h2B8}, 16'h0, 16'h3, 16'hA, 16'hA);
      meas(60 * nv[i], 40 * nv[i]);
      chk(hi_r[0], 40 * nv[i]);
      chk(hi_r[1], 12 * nv[i]);
      chk(hi_r[2], 40 * nv[i]);
      chk(tg_r[1], 32'h4);
      apb(1'h0, `PFC_OFS_FLAGS, 32'h0);
      chk(rd, 32'h1F);
    end
    // active TOP loads only at BOTTOM: preload it so mode 9 starts legal
    apb(1'h1, `PFC_OFS_CMP_A, 32'h5);
    repeat (1300) @(posedge clk_sys);
    // mode 9, TOP 5: A toggles, B toggle falls back, C above TOP
    setup(16'hE659, 16'h5, 16'h2, 16'h7, 16'h0);
    meas(30, 40);
    chk(hi_r[0], 32'h14);
    chk(hi_r[1], 32'h0);
    chk(tg_r[2], 32'h0);
    apb(1'h0, `PFC_OFS_FLAGS, 32'h0);
    chk(rd, 32'h7);
    rst_b <= 1'h0;
    repeat (2) @(posedge clk_sys);
    chk(pin_oe, 32'h0);
    chk(pin_out, 32'h0);
    rst_b <= 1'h1;
    apb(1'h0, `PFC_OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, `PFC_OFS_COUNT, 32'h0);
    chk(rd, 32'h0);
    conclude();
  end
endmodule
